// >>> blkcmd_defs.svh
`ifndef BLKCMD_DEFS_SVH
`define BLKCMD_DEFS_SVH

// Command and response codes carried in the first byte of a frame.
`define BLKCMD_CMD_READ    8'h06
`define BLKCMD_CMD_WRITE   8'h08
`define BLKCMD_RSP_READ    8'h07
`define BLKCMD_RSP_WRITE   8'h09

// Frame geometry.
`define BLKCMD_ID_LAST     8'h07
`define BLKCMD_BLK_LAST    4'hF
`define BLKCMD_LIST_DEPTH  15

// Service and block count limits.
`define BLKCMD_CNT_MIN     8'h01
`define BLKCMD_RD_K_MAX    8'h0F
`define BLKCMD_WR_K_MAX    8'h0B
`define BLKCMD_RD_M_MAX_RF 8'h0D
`define BLKCMD_RD_M_MAX    8'h0F
`define BLKCMD_WR_K_SPLIT  8'h08
`define BLKCMD_WR_M_MAX_LO 8'h0C
`define BLKCMD_WR_M_MAX_HI 8'h0B

// Status flag values.
`define BLKCMD_ST1_OK      8'h00
`define BLKCMD_ST1_ERR     8'hFF
`define BLKCMD_ST2_OK      8'h00
`define BLKCMD_ST2_KCNT    8'hA1
`define BLKCMD_ST2_MCNT    8'hA2
`define BLKCMD_ST2_SVC     8'hA3

// Response byte positions and block list element format.
`define BLKCMD_IDX_ST1     8'h09
`define BLKCMD_IDX_ST2     8'h0A
`define BLKCMD_IDX_M       8'h0B
`define BLKCMD_ELEM_SHORT  7

`endif

// >>> blkcmd_engine.sv
// Functional notes
// - Read request: 0x06, id, k, services, m, list.
// - Tunnel mode reads come from the host.
// - Read service count must be 1 to 15.
// - RF mode read block count 1 to 13.
// - Other modes read block count 1 to 15.
// - Service identifier values themselves are ignored.
// - Multiple services must all carry one value.
// - Out-of-range counts answer error, no transfer.
// - Read answer: 0x07, id, flags, m, data.
// - Error answer omits block count and data.
// - Write request: 0x08, same header, then data.
// - Tunnel mode writes go to the host.
// - Write service count must be 1 to 11.
// - Write, 1-8 services: block count 1 to 12.
// - Write, 9-11 services: block count 1 to 11.
// - Bad service count reports 0xFF, 0xA1.
// - Bad block count reports 0xFF, 0xA2.
// - Mismatched services report 0xFF, 0xA3.
`timescale 1ns/1ps
`default_nettype none
`include "blkcmd_defs.svh"

module blkcmd_engine (
    input  wire logic        sys_clk_in,     // System clock, 10 MHz.
    input  wire logic        nrst_in,        // Asynchronous reset, active low.
    input  wire logic        ce_in,          // Clock enable; low freezes all state.
    input  wire logic        rf_mode_in,     // High in RF communication mode.
    input  wire logic        tunnel_mode_in, // High in tunnel mode.
    input  wire logic [7:0]  rx_byte_in,     // Received command byte.
    input  wire logic        rx_valid_in,    // Received byte is present.
    input  wire logic        rx_last_in,     // Received byte ends the frame.
    output logic             rx_ready_out,   // Engine takes a byte this cycle.
    output logic [7:0]       tx_byte_out,    // Response byte.
    output logic             tx_valid_out,   // Response byte is present.
    output logic             tx_last_out,    // Response byte ends the frame.
    input  wire logic        tx_ready_in,    // Response byte is taken.
    output logic             acc_req_out,    // Storage access request.
    output logic             acc_we_out,     // Access is a write.
    output logic             acc_host_out,   // Access goes to the host.
    output logic [15:0]      acc_blk_out,    // Block number.
    output logic [3:0]       acc_off_out,    // Byte within the block.
    output logic [7:0]       acc_wdata_out,  // Write byte.
    input  wire logic [7:0]  acc_rdata_in,   // Read byte, valid with acknowledge.
    input  wire logic        acc_ack_in      // Access complete.
);
    logic              rst_meta_q;  // First reset synchroniser stage.
    logic              rst_n_q;     // Synchronised reset, active low.
    blkcmd_pkg::cmd_regs_t q;       // Registered state.
    blkcmd_pkg::cmd_regs_t d;       // Next state.
    logic              take;        // A received byte is accepted.
    logic              k_ok;        // Service count within range.
    logic              m_ok;        // Block count within range.
    logic [7:0]        lim_k;       // Service count under test.
    logic [7:0]        rsp_final;   // Index of the last header byte.
    logic              rd_ok;       // Read completes with block data.

    // Reset is asserted at once and released through two flip-flops.
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // The count under test is the incoming byte while the count is arriving.
    assign lim_k = (q.st == blkcmd_pkg::ST_SCNT) ? rx_byte_in : q.k;

    // Count range checks.
    blkcmd_limits u_limits (
        .is_wr_in   (q.is_wr),
        .rf_mode_in (rf_mode_in),
        .k_in       (lim_k),
        .m_in       (rx_byte_in),
        .k_ok_out   (k_ok),
        .m_ok_out   (m_ok)
    );

    assign take      = q.rx_ready && rx_valid_in;
    assign rd_ok     = !q.is_wr && (q.err == `BLKCMD_ST2_OK);
    assign rsp_final = rd_ok ? `BLKCMD_IDX_M : `BLKCMD_IDX_ST2;

    // Byte of the response header at a given position.
    function automatic logic [7:0] rsp_byte(input blkcmd_pkg::cmd_regs_t s, input logic [7:0] i);
        logic ok;
        ok = (s.err == `BLKCMD_ST2_OK);
        if (i == 8'h00) begin
            rsp_byte = s.is_wr ? `BLKCMD_RSP_WRITE : `BLKCMD_RSP_READ;
        end else if (i <= 8'h08) begin
            rsp_byte = s.id[3'(i - 8'h01)];
        end else if (i == `BLKCMD_IDX_ST1) begin
            rsp_byte = ok ? `BLKCMD_ST1_OK : `BLKCMD_ST1_ERR;
        end else if (i == `BLKCMD_IDX_ST2) begin
            rsp_byte = s.err;
        end else begin
            rsp_byte = s.m;
        end
    endfunction : rsp_byte

    // Next-state logic for the whole command engine.
    always_comb begin
        d = q;
        case (q.st)
            // Command code decides read, write or a frame to drop.
            blkcmd_pkg::ST_IDLE: begin
                if (take) begin
                    d.idx       = 8'h00;
                    d.err       = `BLKCMD_ST2_OK;
                    d.last_seen = 1'b0;
                    d.tun       = tunnel_mode_in;
                    d.is_wr     = (rx_byte_in == `BLKCMD_CMD_WRITE);
                    if (rx_byte_in == `BLKCMD_CMD_READ || rx_byte_in == `BLKCMD_CMD_WRITE) begin
                        d.st = blkcmd_pkg::ST_ID;
                    end else begin
                        d.st = blkcmd_pkg::ST_DROP;
                    end
                end
            end
            // Card identifier, kept for the echo in the answer.
            blkcmd_pkg::ST_ID: begin
                if (take) begin
                    d.id[q.idx[2:0]] = rx_byte_in;
                    d.idx            = q.idx + 8'h01;
                    if (q.idx == `BLKCMD_ID_LAST) begin
                        d.st = blkcmd_pkg::ST_SCNT;
                    end
                end
            end
            // Service count; a bad one makes the list unparseable.
            blkcmd_pkg::ST_SCNT: begin
                if (take) begin
                    d.k   = rx_byte_in;
                    d.idx = 8'h00;
                    if (k_ok) begin
                        d.st = blkcmd_pkg::ST_SLIST;
                    end else begin
                        d.err = `BLKCMD_ST2_KCNT;
                        d.st  = blkcmd_pkg::ST_SKIP;
                    end
                end
            end
            // Service identifiers: only their agreement matters.
            blkcmd_pkg::ST_SLIST: begin
                if (take) begin
                    d.idx = q.idx + 8'h01;
                    if (!q.idx[0]) begin
                        d.sid_hi = rx_byte_in;
                    end else if (q.idx == 8'h01) begin
                        d.sid0 = {q.sid_hi, rx_byte_in};
                    end else if ({q.sid_hi, rx_byte_in} != q.sid0 && q.err == `BLKCMD_ST2_OK) begin
                        d.err = `BLKCMD_ST2_SVC;
                    end
                    if (q.idx == {q.k[6:0], 1'b0} - 8'h01) begin
                        d.st = blkcmd_pkg::ST_BCNT;
                    end
                end
            end
            // Block count; the first error found is the one reported.
            blkcmd_pkg::ST_BCNT: begin
                if (take) begin
                    d.m    = rx_byte_in;
                    d.ecnt = 4'h0;
                    d.epos = 2'd0;
                    if (!m_ok && q.err == `BLKCMD_ST2_OK) begin
                        d.err = `BLKCMD_ST2_MCNT;
                    end
                    d.st = (m_ok && q.err == `BLKCMD_ST2_OK) ? blkcmd_pkg::ST_BLIST
                                                              : blkcmd_pkg::ST_SKIP;
                end
            end
            // Block list: bit 7 of the first byte selects a 2-byte element.
            blkcmd_pkg::ST_BLIST: begin
                if (take) begin
                    if (q.epos == 2'd0) begin
                        d.elen2 = rx_byte_in[`BLKCMD_ELEM_SHORT];
                        d.epos  = 2'd1;
                    end else if (q.epos == 2'd1 && !q.elen2) begin
                        d.bnum = {8'h00, rx_byte_in};
                        d.epos = 2'd2;
                    end else begin
                        d.blist[q.ecnt] = (q.epos == 2'd1) ? {8'h00, rx_byte_in}
                                                           : {rx_byte_in, q.bnum[7:0]};
                        d.epos = 2'd0;
                        d.ecnt = q.ecnt + 4'h1;
                        if ({4'h0, q.ecnt + 4'h1} == q.m) begin
                            d.ecnt = 4'h0;
                            d.off  = 4'h0;
                            d.st   = q.is_wr ? blkcmd_pkg::ST_WDATA : blkcmd_pkg::ST_SKIP;
                        end
                    end
                end
            end
            // Each write byte is stored before the next is taken.
            blkcmd_pkg::ST_WDATA: begin
                if (take) begin
                    d.acc_req   = 1'b1;
                    d.acc_we    = 1'b1;
                    d.acc_host  = q.tun;
                    d.acc_blk   = q.blist[q.ecnt];
                    d.acc_off   = q.off;
                    d.acc_wdata = rx_byte_in;
                    d.st        = blkcmd_pkg::ST_WMEM;
                end
            end
            blkcmd_pkg::ST_WMEM: begin
                if (acc_ack_in) begin
                    d.acc_req = 1'b0;
                    d.acc_we  = 1'b0;
                    d.off     = q.off + 4'h1;
                    if (q.off == `BLKCMD_BLK_LAST) begin
                        d.ecnt = q.ecnt + 4'h1;
                    end
                    if ((q.off == `BLKCMD_BLK_LAST && {4'h0, q.ecnt + 4'h1} == q.m)
                        || q.last_seen) begin
                        d.idx = 8'h00;
                        d.st  = blkcmd_pkg::ST_RESP;
                    end else begin
                        d.st = blkcmd_pkg::ST_WDATA;
                    end
                end
            end
            // Header bytes go out one handshake at a time.
            blkcmd_pkg::ST_RESP: begin
                if (q.tx_valid && tx_ready_in) begin
                    d.tx_valid = 1'b0;
                    d.tx_last  = 1'b0;
                    d.idx      = q.idx + 8'h01;
                    if (q.idx == rsp_final) begin
                        d.ecnt = 4'h0;
                        d.off  = 4'h0;
                        d.st   = rd_ok ? blkcmd_pkg::ST_RDMEM : blkcmd_pkg::ST_IDLE;
                    end
                end else if (!q.tx_valid) begin
                    d.tx_valid = 1'b1;
                    d.tx_byte  = rsp_byte(q, q.idx);
                    d.tx_last  = (q.idx == rsp_final) && !rd_ok;
                end
            end
            // Block data fetched a byte at a time from store or host.
            blkcmd_pkg::ST_RDMEM: begin
                if (!q.acc_req) begin
                    d.acc_req  = 1'b1;
                    d.acc_host = q.tun;
                    d.acc_blk  = q.blist[q.ecnt];
                    d.acc_off  = q.off;
                end else if (acc_ack_in) begin
                    d.acc_req  = 1'b0;
                    d.tx_valid = 1'b1;
                    d.tx_byte  = acc_rdata_in;
                    d.tx_last  = (q.off == `BLKCMD_BLK_LAST) && ({4'h0, q.ecnt + 4'h1} == q.m);
                    d.st       = blkcmd_pkg::ST_RDTX;
                end
            end
            blkcmd_pkg::ST_RDTX: begin
                if (tx_ready_in) begin
                    d.tx_valid = 1'b0;
                    d.tx_last  = 1'b0;
                    d.off      = q.off + 4'h1;
                    if (q.off == `BLKCMD_BLK_LAST) begin
                        d.ecnt = q.ecnt + 4'h1;
                    end
                    d.st = q.tx_last ? blkcmd_pkg::ST_IDLE : blkcmd_pkg::ST_RDMEM;
                end
            end
            // SKIP and DROP wait for the frame end.
            default: begin
            end
        endcase
        // The frame end decides between answering and dropping the frame.
        if (take) begin
            d.last_seen = rx_last_in;
            if (rx_last_in && d.st != blkcmd_pkg::ST_WMEM && q.st != blkcmd_pkg::ST_IDLE) begin
                d.idx = 8'h00;
                if (d.st == blkcmd_pkg::ST_SKIP || d.err != `BLKCMD_ST2_OK) begin
                    d.st = blkcmd_pkg::ST_RESP;
                end else begin
                    d.st = blkcmd_pkg::ST_IDLE;
                end
            end else if (rx_last_in && q.st == blkcmd_pkg::ST_IDLE) begin
                d.st = blkcmd_pkg::ST_IDLE;
            end
        end
        d.rx_ready = (d.st != blkcmd_pkg::ST_WMEM) && (d.st != blkcmd_pkg::ST_RESP)
                  && (d.st != blkcmd_pkg::ST_RDMEM) && (d.st != blkcmd_pkg::ST_RDTX);
    end

    // State register; the clock enable freezes everything.
    always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            q    <= '0;
            q.st <= blkcmd_pkg::ST_IDLE;
        end else if (ce_in) begin
            q <= d;
        end
    end

    assign rx_ready_out  = q.rx_ready;
    assign tx_byte_out   = q.tx_byte;
    assign tx_valid_out  = q.tx_valid;
    assign tx_last_out   = q.tx_last;
    assign acc_req_out   = q.acc_req;
    assign acc_we_out    = q.acc_we;
    assign acc_host_out  = q.acc_host;
    assign acc_blk_out   = q.acc_blk;
    assign acc_off_out   = q.acc_off;
    assign acc_wdata_out = q.acc_wdata;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_q);

    // Checks on the command engine.
    cmd_decode_a: assert property (ce_in && take && q.st == blkcmd_pkg::ST_IDLE && !rx_last_in
        && rx_byte_in == `BLKCMD_CMD_READ |=> q.st == blkcmd_pkg::ST_ID && !q.is_wr)
        else $error("read code not decoded");
    kcnt_error_a: assert property (ce_in && take && q.st == blkcmd_pkg::ST_SCNT && !k_ok
        |=> q.err == `BLKCMD_ST2_KCNT)
        else $error("bad service count not flagged");
    mcnt_error_a: assert property (ce_in && take && q.st == blkcmd_pkg::ST_BCNT && !m_ok
        && q.err == `BLKCMD_ST2_OK |=> q.err == `BLKCMD_ST2_MCNT)
        else $error("bad block count not flagged");
    svc_mismatch_a: assert property (ce_in && take && q.st == blkcmd_pkg::ST_SLIST && q.idx[0]
        && q.idx != 8'h01 && {q.sid_hi, rx_byte_in} != q.sid0 |=> q.err != `BLKCMD_ST2_OK)
        else $error("service mismatch not flagged");
    no_err_access_a: assert property (q.acc_req |-> q.err == `BLKCMD_ST2_OK
        && (q.st == blkcmd_pkg::ST_WMEM || q.st == blkcmd_pkg::ST_RDMEM))
        else $error("storage touched by a rejected command");
    host_route_a: assert property (q.acc_req |-> q.acc_host == q.tun)
        else $error("access not routed by tunnel mode");
    rsp_code_a: assert property (q.st == blkcmd_pkg::ST_RESP && q.tx_valid && q.idx == 8'h00
        |-> q.tx_byte == (q.is_wr ? `BLKCMD_RSP_WRITE : `BLKCMD_RSP_READ))
        else $error("wrong response code");
    err_short_a: assert property (q.st == blkcmd_pkg::ST_RESP && q.tx_valid
        && q.err != `BLKCMD_ST2_OK |-> q.idx <= `BLKCMD_IDX_ST2
        && (q.tx_last == (q.idx == `BLKCMD_IDX_ST2)))
        else $error("error answer not cut after status");
    st1_value_a: assert property (q.st == blkcmd_pkg::ST_RESP && q.tx_valid
        && q.idx == `BLKCMD_IDX_ST1 |-> q.tx_byte == ((q.err == `BLKCMD_ST2_OK)
        ? `BLKCMD_ST1_OK : `BLKCMD_ST1_ERR))
        else $error("wrong status flag 1");
    mcount_echo_a: assert property (q.st == blkcmd_pkg::ST_RESP && q.tx_valid
        && q.idx == `BLKCMD_IDX_M |-> q.tx_byte == q.m ##0 !q.tx_last)
        else $error("block count not echoed");
    read_done_c: cover property (q.st == blkcmd_pkg::ST_RDTX && q.tx_last && tx_ready_in);
    write_done_c: cover property (q.st == blkcmd_pkg::ST_WMEM && acc_ack_in
        ##1 q.st == blkcmd_pkg::ST_RESP);
    error_rsp_c: cover property (q.st == blkcmd_pkg::ST_RESP && q.tx_last
        && q.err == `BLKCMD_ST2_SVC);

endmodule : blkcmd_engine
`default_nettype wire

// >>> blkcmd_limits.sv
`timescale 1ns/1ps
`default_nettype none
`include "blkcmd_defs.svh"

// Range checks on the service count and block count of one command.
module blkcmd_limits (
    input  wire logic       is_wr_in,
    input  wire logic       rf_mode_in,
    input  wire logic [7:0] k_in,
    input  wire logic [7:0] m_in,
    output logic            k_ok_out,
    output logic            m_ok_out
);
    logic [7:0] k_max;  // Largest legal service count.
    logic [7:0] m_max;  // Largest legal block count.

    // Limits depend on direction, link mode and, for writes, the service count.
    always_comb begin
        if (is_wr_in) begin
            k_max = `BLKCMD_WR_K_MAX;
            m_max = (k_in > `BLKCMD_WR_K_SPLIT) ? `BLKCMD_WR_M_MAX_HI
                                                : `BLKCMD_WR_M_MAX_LO;
        end else begin
            k_max = `BLKCMD_RD_K_MAX;
            m_max = rf_mode_in ? `BLKCMD_RD_M_MAX_RF : `BLKCMD_RD_M_MAX;
        end
        k_ok_out = (k_in >= `BLKCMD_CNT_MIN) && (k_in <= k_max);
        m_ok_out = (m_in >= `BLKCMD_CNT_MIN) && (m_in <= m_max);
    end
endmodule : blkcmd_limits
`default_nettype wire

// >>> blkcmd_pkg.sv
`default_nettype none
`include "blkcmd_defs.svh"

package blkcmd_pkg;

    // Phases of one command frame.
    typedef enum logic [3:0] {
        ST_IDLE, ST_ID, ST_SCNT, ST_SLIST, ST_BCNT, ST_BLIST, ST_WDATA,
        ST_WMEM, ST_SKIP, ST_DROP, ST_RESP, ST_RDMEM, ST_RDTX
    } cmd_state_t;

    // All state of the command engine.
    typedef struct packed {
        cmd_state_t  st;
        logic        is_wr;
        logic        tun;
        logic        last_seen;
        logic [7:0]  idx;
        logic [7:0]  k;
        logic [7:0]  m;
        logic [7:0]  err;
        logic [7:0]  sid_hi;
        logic [15:0] sid0;
        logic [7:0][7:0] id;
        logic [`BLKCMD_LIST_DEPTH-1:0][15:0] blist;
        logic [3:0]  ecnt;
        logic [1:0]  epos;
        logic        elen2;
        logic [15:0] bnum;
        logic [3:0]  off;
        logic        rx_ready;
        logic        tx_valid;
        logic        tx_last;
        logic [7:0]  tx_byte;
        logic        acc_req;
        logic        acc_we;
        logic        acc_host;
        logic [15:0] acc_blk;
        logic [3:0]  acc_off;
        logic [7:0]  acc_wdata;
    } cmd_regs_t;

endpackage : blkcmd_pkg
`default_nettype wire

// >>> blkcmd_store_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for memory and host: answers accesses alternately slowly and promptly.
module blkcmd_store_model (
    input  wire logic        clk_in,       // System clock.
    input  wire logic        nrst_in,      // Reset, active low.
    input  wire logic        req_in,       // Access request, held until acknowledged.
    input  wire logic        we_in,        // Access is a write.
    input  wire logic        host_in,      // Access goes to the host.
    input  wire logic [15:0] blk_in,       // Block number.
    input  wire logic [3:0]  off_in,       // Byte within the block.
    input  wire logic [7:0]  wdata_in,     // Write byte.
    output logic      [7:0]  rdata_out,    // Read byte, valid with the acknowledge.
    output logic             ack_out,      // One-cycle acknowledge.
    output int               rd_cnt_out,   // Reads served.
    output int               wr_cnt_out,   // Writes served whose byte matches its offset and block.
    output int               host_cnt_out  // Accesses routed to the host.
);
    logic [1:0] wait_q; // Cycles left before the acknowledge.
    logic       slow_q; // Selects a long wait for the next access.
    // Read data is scrambled outside the acknowledge cycle, so a late sample shows up.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ack_out <= 1'b0;
            rdata_out <= 8'h00;
            wait_q <= 2'h1;
            slow_q <= 1'b0;
            rd_cnt_out <= 0;
            wr_cnt_out <= 0;
            host_cnt_out <= 0;
        end else begin
            ack_out <= 1'b0;
            rdata_out <= ~rdata_out;
            if (req_in && !ack_out && wait_q != 2'h0) begin
                wait_q <= wait_q - 2'h1;
            end else if (req_in && !ack_out) begin
                ack_out <= 1'b1;
                rdata_out <= {off_in, blk_in[3:0]};
                wait_q <= slow_q ? 2'h3 : 2'h0;
                slow_q <= ~slow_q;
                rd_cnt_out <= rd_cnt_out + (we_in ? 0 : 1);
                // Only a write whose byte matches its offset and block pattern counts.
                wr_cnt_out <= wr_cnt_out + ((we_in && wdata_in == {off_in, blk_in[3:0]}) ? 1 : 0);
                host_cnt_out <= host_cnt_out + (host_in ? 1 : 0);
            end
        end
    end
endmodule : blkcmd_store_model
`default_nettype wire

// >>> tb_rf_block_read_write_cmd.sv
`timescale 1ns/1ps
`default_nettype none
// Sends whole command frames and judges each answer and the accesses it caused.
module tb_rf_block_read_write_cmd;
    logic        clk, nrst, rf, tun;                  // Clock, reset and mode levels.
    logic [7:0]  rx_byte, tx_byte, wdata, rdata;      // Data bytes of the three streams.
    logic        rx_valid, rx_last, rx_ready;         // Command stream handshake.
    logic        tx_valid, tx_last, tx_ready;         // Answer stream handshake.
    logic        req, we, host, ack;                  // Access handshake.
    logic [15:0] blk;                                 // Access block.
    logic [3:0]  off;                                 // Access offset.
    logic [7:0]  fr[$], rsp[$], exp[$];               // Frame sent, answer seen and expected.
    int          rd_n, wr_n, hs_n, miscompares, compares;
    blkcmd_engine dut (
        .sys_clk_in(clk), .nrst_in(nrst), .ce_in(1'b1), .rf_mode_in(rf), .tunnel_mode_in(tun),
        .rx_byte_in(rx_byte), .rx_valid_in(rx_valid), .rx_last_in(rx_last), .rx_ready_out(rx_ready),
        .tx_byte_out(tx_byte), .tx_valid_out(tx_valid), .tx_last_out(tx_last), .tx_ready_in(tx_ready),
        .acc_req_out(req), .acc_we_out(we), .acc_host_out(host), .acc_blk_out(blk),
        .acc_off_out(off), .acc_wdata_out(wdata), .acc_rdata_in(rdata), .acc_ack_in(ack));
    blkcmd_store_model store (
        .clk_in(clk), .nrst_in(nrst), .req_in(req), .we_in(we), .host_in(host), .blk_in(blk),
        .off_in(off), .wdata_in(wdata), .rdata_out(rdata), .ack_out(ack), .rd_cnt_out(rd_n),
        .wr_cnt_out(wr_n), .host_cnt_out(hs_n));
    // Free-running 10 MHz clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Prints the verdict and ends the run.
    task automatic stop_test;
        if (miscompares == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got 0x%0h expected 0x%0h", $time, got, want);
        end
    endtask : chk
    // A wait that ran out of its bound counts as a mismatch.
    task automatic hang;
        miscompares++;
        stop_test();
    endtask : hang
    // Sends one frame, collects the answer, checks it and the access counts.
    task automatic run(input logic [7:0] code, k, m, input logic diff, input logic [7:0] st2,
                       input int rd, wr, hs);
        int n, r0, w0, h0;
        r0 = rd_n;
        w0 = wr_n;
        h0 = hs_n;
        fr = {code, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7, k};
        for (int i = 0; i < k; i++) fr = {fr, 8'h09, (diff && i == k - 1) ? 8'h01 : 8'h00};
        fr.push_back(m);
        for (int i = 0; i < m; i++) begin
            if (i[0]) fr = {fr, 8'h00, 8'(i + 3), 8'h00};
            else fr = {fr, 8'h80, 8'(i + 3)};
        end
        // Each write byte carries its offset and block, so the store can judge it.
        if (code == 8'h08) for (int i = 0; i < 16 * m; i++)
                fr.push_back({4'(i % 16), 4'(i / 16 + 3)});
        foreach (fr[i]) begin
            rx_valid = 1'b1;
            rx_byte = fr[i];
            rx_last = (i == fr.size() - 1);
            for (n = 0; n < 500 && rx_ready !== 1'b1; n++) @(posedge clk) #1;
            if (n == 500) hang();
            @(posedge clk) #1;
        end
        rx_valid = 1'b0;
        rx_last = 1'b0;
        rsp = {};
        // The sink stalls two cycles in four, so each byte must stand until taken.
        for (n = 0; n < 5000 && !(tx_valid === 1'b1 && tx_last === 1'b1); n++) begin
            tx_ready = n[1];
            if (tx_valid === 1'b1 && tx_ready) rsp.push_back(tx_byte);
            @(posedge clk) #1;
        end
        if (n == 5000) hang();
        tx_ready = 1'b1;
        rsp.push_back(tx_byte);
        @(posedge clk) #1;
        tx_ready = 1'b0;
        exp = {code + 8'h01, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7,
               (st2 == 8'h00) ? 8'h00 : 8'hFF, st2};
        if (st2 == 8'h00 && code == 8'h06) begin
            exp.push_back(m);
            for (int b = 0; b < m; b++) for (int o = 0; o < 16; o++) exp.push_back({4'(o), 4'(b + 3)});
        end
        chk(rsp.size(), exp.size());
        foreach (exp[i]) chk(rsp[i], exp[i]);
        chk(rd_n - r0, rd);
        chk(wr_n - w0, wr);
        chk(hs_n - h0, hs);
    endtask : run
    // Plain reads from own memory, then from the host at the count limits.
    task automatic reads_ok;
        run(8'h06, 8'h02, 8'h02, 1'b0, 8'h00, 32, 0, 0);
        run(8'h06, 8'h01, 8'h0D, 1'b0, 8'h00, 208, 0, 0);
        tun = 1'b1;
        rf = 1'b0;
        run(8'h06, 8'h0F, 8'h0F, 1'b0, 8'h00, 240, 0, 240);
    endtask : reads_ok
    // Reads with counts just outside their ranges, or with mismatched services, end at the status flags.
    task automatic reads_bad;
        run(8'h06, 8'h00, 8'h01, 1'b0, 8'hA1, 0, 0, 0);
        run(8'h06, 8'h10, 8'h01, 1'b0, 8'hA1, 0, 0, 0);
        run(8'h06, 8'h01, 8'h10, 1'b0, 8'hA2, 0, 0, 0);
        run(8'h06, 8'h01, 8'h00, 1'b0, 8'hA2, 0, 0, 0);
        rf = 1'b1;
        run(8'h06, 8'h01, 8'h0E, 1'b0, 8'hA2, 0, 0, 0);
        run(8'h06, 8'h03, 8'h01, 1'b1, 8'hA3, 0, 0, 0);
    endtask : reads_bad
    // Writes to the host and to memory at both block limits, and rejected writes.
    task automatic writes;
        run(8'h08, 8'h08, 8'h0C, 1'b0, 8'h00, 0, 192, 192);
        tun = 1'b0;
        run(8'h08, 8'h09, 8'h0B, 1'b0, 8'h00, 0, 176, 0);
        run(8'h08, 8'h09, 8'h0C, 1'b0, 8'hA2, 0, 0, 0);
        run(8'h08, 8'h08, 8'h0D, 1'b0, 8'hA2, 0, 0, 0);
        run(8'h08, 8'h0C, 8'h01, 1'b0, 8'hA1, 0, 0, 0);
        run(8'h08, 8'h02, 8'h01, 1'b1, 8'hA3, 0, 0, 0);
    endtask : writes
    // Reset for four cycles, then the scenarios in turn.
    initial begin
        nrst = 1'b0;
        rf = 1'b1;
        tun = 1'b0;
        rx_byte = 8'h00;
        rx_valid = 1'b0;
        rx_last = 1'b0;
        tx_ready = 1'b0;
        miscompares = 0;
        compares = 0;
        repeat (4) @(posedge clk);
        #1 nrst = 1'b1;
        reads_ok();
        reads_bad();
        writes();
        stop_test();
    end
endmodule : tb_rf_block_read_write_cmd
`default_nettype wire
